//--- hw/acs_pkg.sv
// Package for the conversion sequencer: register map, field layout, timing.
// Assumes a 32-bit AXI4-Lite bus and a 100 MHz system clock.
package acs_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00; // Start, trigger, enables, gains
    localparam logic [7:0] ADDR_CFG0     = 8'h04; // Acquisition config, first word
    localparam logic [7:0] ADDR_OFFSET   = 8'h08; // Stage 2 and 3 offsets
    localparam logic [7:0] ADDR_STATUS   = 8'h0c; // Busy, resolution
    localparam logic [7:0] ADDR_RESULT   = 8'h10; // Conversion result word
    // Control register fields
    localparam int CTRL_START    = 0;
    localparam int CTRL_ALT      = 1;
    localparam int CTRL_EN_LO    = 4;  // Enable word: adc, stage1..3
    localparam int CTRL_S1_GAIN  = 8;
    localparam int CTRL_S2_G_LO  = 9;
    localparam int CTRL_S3_G_LO  = 16;
    // First acquisition config fields
    localparam int CFG_OSR_LO    = 2;
    localparam int CFG_NELC_LO   = 5;
    localparam int CFG_FIN_LO    = 7;
    // Offset register fields
    localparam int OFS_S2_LO     = 0;
    localparam int OFS_S3_LO     = 8;
    // Sample-rate divisors in RC ticks, per variant
    localparam logic [11:0] DIV_A0 = 12'h004;
    localparam logic [11:0] DIV_A1 = 12'h008;
    localparam logic [11:0] DIV_A2 = 12'h020;
    localparam logic [11:0] DIV_B0 = 12'h008;
    localparam logic [11:0] DIV_B1 = 12'h010;
    localparam logic [11:0] DIV_B2 = 12'h040;
    // Overhead system cycles before first and after last elementary conversion
    localparam logic [3:0] HEAD_CYCLES = 4'h2;
    localparam logic [3:0] TAIL_CYCLES = 4'h2;
    // Resolution base and cap
    localparam logic [4:0] RES_BASE = 5'h06;
    localparam logic [4:0] RES_MAX  = 5'h10;
    localparam logic [2:0] OSR_BASE_LOG = 3'h3;
    typedef enum logic [2:0] {ST_IDLE, ST_HEAD, ST_CONV, ST_QUANT, ST_TAIL} acs_state_t;
endpackage : acs_pkg

//--- hw/acs_sequencer.sv
// Oversampled incremental ADC conversion sequencer with amplifier-chain decode.
// Assumes an AXI4-Lite master on i_clk, an RC-derived tick pin and a modulator bit pin.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer #(
    parameter bit VARIANT_B = 1'b0  // Second device variant divisors
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // AXI4-Lite slave
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // Front end
    input  wire logic        i_rc_tick,      // RC oscillator edge, asynchronous
    input  wire logic        i_slow_tick,    // ~8 kHz reference tick, asynchronous
    input  wire logic        i_mod_bit,      // Modulator output bit, asynchronous
    output logic             o_sample_clk,   // One-cycle sampling enable
    output logic             o_offset_neg,   // Offset polarity of current conversion
    output logic             o_integ_reset,  // Integrator reset at conversion start
    output logic             o_quantize,     // Final quantization step
    output logic [3:0]       o_enable,       // adc, stage1, stage2, stage3
    output logic             o_s1_gain10,
    output logic [3:0]       o_s2_gain,      // Decoded gain value 1/2/5/10
    output logic [3:0]       o_s2_offset,
    output logic [6:0]       o_s3_gain_twelfths,
    output logic [6:0]       o_s3_offset,
    output logic             o_busy,
    output logic [15:0]      o_result,
    output logic [4:0]       o_resolution
);
    // Every flop of the block lives in this one record, cleared together on reset
    typedef struct packed {
        logic [1:0]  rc_sync;     // Two-stage synchroniser, RC edge
        logic        rc_prev;
        logic [1:0]  slow_sync;
        logic        slow_prev;
        logic [1:0]  mod_sync;
        logic [11:0] div_cnt;
        logic        fs_tick;
        acs_pkg::acs_state_t st;
        logic [3:0]  ovh_cnt;
        logic [10:0] smp_cnt;     // Up to 1024+1 samples
        logic [3:0]  elc_cnt;     // Up to 8 conversions
        logic [10:0] elc_acc;
        logic [13:0] sum;         // 8 x 11 bits
        logic        neg;
        logic [31:0] ctrl;
        logic [31:0] cfg0;
        logic [31:0] ofs;
        logic [15:0] result;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } acs_regs_t;

    acs_regs_t s_reg, s_next;
    // Decoded configuration and strobes, all combinational
    logic [2:0]  osr_code;
    logic [3:0]  osr_log;
    logic [1:0]  nelc_code;
    logic [1:0]  fin_code;
    logic [10:0] osr_val;
    logic [3:0]  nelc_val;
    logic [11:0] div_sel;
    logic [4:0]  res_raw;
    logic        start_req;
    logic        rc_edge;
    logic        slow_edge;
    logic [31:0] wmask;
    logic [15:0] mean;

    // Field decode from the first acquisition config word
    assign osr_code  = s_reg.cfg0[acs_pkg::CFG_OSR_LO +: 3];
    assign nelc_code = s_reg.cfg0[acs_pkg::CFG_NELC_LO +: 2];
    assign fin_code  = s_reg.cfg0[acs_pkg::CFG_FIN_LO +: 2];
    // Shift amount kept four bits wide so codes from five upward do not wrap
    assign osr_log   = 4'(osr_code) + 4'(acs_pkg::OSR_BASE_LOG);
    assign osr_val   = 11'(11'h001 << osr_log);
    assign nelc_val  = 4'(4'h1 << nelc_code);
    // Resolution grows with both codes, capped by result width
    assign res_raw   = acs_pkg::RES_BASE + 5'({osr_code, 1'b0}) + 5'(nelc_code);
    assign o_resolution = (res_raw > acs_pkg::RES_MAX) ? acs_pkg::RES_MAX : res_raw;

    // Divisor per rate code; code 11 follows the slow reference tick
    always_comb begin
        unique case (fin_code)
            2'b00:   div_sel = VARIANT_B ? acs_pkg::DIV_B0 : acs_pkg::DIV_A0;
            2'b01:   div_sel = VARIANT_B ? acs_pkg::DIV_B1 : acs_pkg::DIV_A1;
            2'b10:   div_sel = VARIANT_B ? acs_pkg::DIV_B2 : acs_pkg::DIV_A2;
            default: div_sel = acs_pkg::DIV_A0;
        endcase
    end

    // Amplifier chain decode, straight from configuration
    assign o_enable     = s_reg.ctrl[acs_pkg::CTRL_EN_LO +: 4];
    assign o_s1_gain10  = s_reg.ctrl[acs_pkg::CTRL_S1_GAIN];
    assign o_s2_offset  = s_reg.ofs[acs_pkg::OFS_S2_LO +: 4];
    assign o_s3_gain_twelfths = s_reg.ctrl[acs_pkg::CTRL_S3_G_LO +: 7];
    assign o_s3_offset  = s_reg.ofs[acs_pkg::OFS_S3_LO +: 7];
    // Stage two gain table: code to whole gain
    always_comb begin
        unique case (s_reg.ctrl[acs_pkg::CTRL_S2_G_LO +: 2])
            2'b00: o_s2_gain = 4'h1;
            2'b01: o_s2_gain = 4'h2;
            2'b10: o_s2_gain = 4'h5;
            2'b11: o_s2_gain = 4'ha;
        endcase
    end

    // Mean: shifting by the count code divides by a power of two
    // Truncating: dropped low bits are not rounded
    assign mean = 16'(s_reg.sum >> nelc_code);

    // Rising edges of the synchronised ticks; prev clears low like the idle pins
    assign rc_edge   = s_reg.rc_sync[1] & ~s_reg.rc_prev;
    assign slow_edge = s_reg.slow_sync[1] & ~s_reg.slow_prev;

    // Write byte mask from strobes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_reg.wstrb[i]}};
        end
    end

    // Readies drop while a transfer is held or its response is pending
    assign o_awready    = ~s_reg.aw_got & ~s_reg.bvalid;
    assign o_wready     = ~s_reg.w_got & ~s_reg.bvalid;
    assign o_bvalid     = s_reg.bvalid;
    assign o_bresp      = s_reg.bresp;
    assign o_arready    = ~s_reg.rvalid;
    assign o_rvalid     = s_reg.rvalid;
    assign o_rdata      = s_reg.rdata;
    assign o_rresp      = s_reg.rresp;

    // Front-end controls; integrator reset marks the first period of a conversion
    assign o_sample_clk = s_reg.fs_tick;
    assign o_offset_neg = s_reg.neg;
    assign o_quantize   = (s_reg.st == acs_pkg::ST_QUANT);
    assign o_busy       = (s_reg.st != acs_pkg::ST_IDLE);
    assign o_result     = s_reg.result;
    assign o_integ_reset = (s_reg.st == acs_pkg::ST_CONV) && (s_reg.smp_cnt == 11'h000);

    // Whole next-state computation
    always_comb begin
        // Hold everything; each section below edits only its own fields
        s_next = s_reg;
        start_req = 1'b0;
        // Synchronisers; only the second stage is read
        s_next.rc_sync   = {s_reg.rc_sync[0], i_rc_tick};
        s_next.rc_prev   = s_reg.rc_sync[1];
        s_next.slow_sync = {s_reg.slow_sync[0], i_slow_tick};
        s_next.slow_prev = s_reg.slow_sync[1];
        s_next.mod_sync  = {s_reg.mod_sync[0], i_mod_bit};

        // Sampling enable from RC edges
        s_next.fs_tick = 1'b0;
        // Slow code bypasses the divider, whose count is then frozen
        if (fin_code == 2'b11) begin
            s_next.fs_tick = slow_edge;
        end else if (rc_edge) begin
            if (s_reg.div_cnt >= div_sel - 12'h001) begin
                s_next.div_cnt = 12'h000;
                s_next.fs_tick = 1'b1;
            end else begin
                s_next.div_cnt = s_reg.div_cnt + 12'h001;
            end
        end

        // AXI write: address and data in either order
        if (i_awvalid && o_awready) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = i_awaddr;
        end
        // Data may arrive before, with or after its address
        if (i_wvalid && o_wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = i_wdata;
            s_next.wstrb = i_wstrb;
        end
        // Both halves held: commit now, answer on the next edge
        if (s_reg.aw_got && s_reg.w_got) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = 2'b00;
            unique case ({s_reg.awaddr[7:2], 2'b00})
                // Only byte zero carries the start and trigger bits
                acs_pkg::ADDR_CTRL: begin
                    s_next.ctrl = (s_reg.ctrl & ~wmask) | (s_reg.wdata & wmask);
                    start_req = s_reg.wstrb[0] & (s_reg.wdata[acs_pkg::CTRL_START]
                                | s_reg.wdata[acs_pkg::CTRL_ALT]);
                end
                acs_pkg::ADDR_CFG0:   s_next.cfg0 = (s_reg.cfg0 & ~wmask) | (s_reg.wdata & wmask);
                acs_pkg::ADDR_OFFSET: s_next.ofs  = (s_reg.ofs & ~wmask) | (s_reg.wdata & wmask);
                acs_pkg::ADDR_STATUS, acs_pkg::ADDR_RESULT: s_next.bresp = 2'b00;
                default:              s_next.bresp = 2'b10;
            endcase
            // Start and trigger bits self-clear
            s_next.ctrl[acs_pkg::CTRL_START] = 1'b0;
            s_next.ctrl[acs_pkg::CTRL_ALT]   = 1'b0;
        end
        // Response leaves once the master has taken it
        if (s_reg.bvalid && i_bready) begin
            s_next.bvalid = 1'b0;
        end

        // AXI read
        if (i_arvalid && o_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = 2'b00;
            // Status packs resolution over busy; unused bits read zero
            unique case ({i_araddr[7:2], 2'b00})
                acs_pkg::ADDR_CTRL:   s_next.rdata = s_reg.ctrl;
                acs_pkg::ADDR_CFG0:   s_next.rdata = s_reg.cfg0;
                acs_pkg::ADDR_OFFSET: s_next.rdata = s_reg.ofs;
                acs_pkg::ADDR_STATUS: s_next.rdata = {26'h0, o_resolution, o_busy};
                acs_pkg::ADDR_RESULT: s_next.rdata = {16'h0, s_reg.result};
                default: begin
                    s_next.rdata = 32'h0;
                    s_next.rresp = 2'b10;
                end
            endcase
        end else if (s_reg.rvalid && i_rready) begin
            // Read data stand until the master takes them
            s_next.rvalid = 1'b0;
        end

        // Conversion sequence
        // Busy is simply any state but idle
        unique case (s_reg.st)
            acs_pkg::ST_IDLE: begin
                // Start acts only here, so a start during a run is lost
                if (start_req) begin
                    s_next.st      = acs_pkg::ST_HEAD;
                    s_next.ovh_cnt = 4'h0;
                    s_next.elc_cnt = 4'h0;
                    s_next.sum     = 14'h0;
                    s_next.neg     = 1'b0;
                end
            end
            acs_pkg::ST_HEAD: begin
                // Setup cycles before first conversion
                s_next.ovh_cnt = s_reg.ovh_cnt + 4'h1;
                if (s_reg.ovh_cnt == acs_pkg::HEAD_CYCLES - 4'h1) begin
                    s_next.st      = acs_pkg::ST_CONV;
                    s_next.smp_cnt = 11'h000;
                    s_next.elc_acc = 11'h000;
                end
            end
            acs_pkg::ST_CONV: begin
                // Start requests here are dropped, not queued
                if (s_reg.fs_tick) begin
                    s_next.smp_cnt = s_reg.smp_cnt + 11'h001;
                    // Count ones seen through the current offset polarity
                    if (s_reg.mod_sync[1] ^ s_reg.neg) begin
                        s_next.elc_acc = s_reg.elc_acc + 11'h001;
                    end
                    // Last of the ratio plus one periods closes this conversion
                    if (s_reg.smp_cnt == osr_val) begin
                        s_next.sum     = s_reg.sum + 14'(s_next.elc_acc);
                        s_next.elc_cnt = s_reg.elc_cnt + 4'h1;
                        s_next.neg     = ~s_reg.neg;
                        s_next.smp_cnt = 11'h000;
                        s_next.elc_acc = 11'h000;
                        if (s_reg.elc_cnt == nelc_val - 4'h1) begin
                            s_next.st = acs_pkg::ST_QUANT;
                        end
                    end
                end
            end
            acs_pkg::ST_QUANT: begin
                // One sampling period of final quantization
                if (s_reg.fs_tick) begin
                    s_next.st      = acs_pkg::ST_TAIL;
                    s_next.ovh_cnt = 4'h0;
                end
            end
            acs_pkg::ST_TAIL: begin
                // Close-out cycles; result and busy change on one edge
                s_next.ovh_cnt = s_reg.ovh_cnt + 4'h1;
                if (s_reg.ovh_cnt == acs_pkg::TAIL_CYCLES - 4'h1) begin
                    s_next.result = mean;
                    s_next.st     = acs_pkg::ST_IDLE;
                end
            end
            // Unused state codes fall back to idle
            default: s_next.st = acs_pkg::ST_IDLE;
        endcase
    end

    // State register
    // Asynchronous clear loads only constants
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : acs_sequencer
`default_nettype wire

//--- bench/acs_sequencer_sva.sv
// Checker for the conversion sequencer: bus handshakes and sequence timing.
// Assumes a bind onto acs_sequencer, one clock domain, reset active low.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_sva (
    input wire logic       i_clk,
    input wire logic       i_rstn,
    input wire logic       i_arvalid,
    input wire logic       o_arready,
    input wire logic       o_awready,
    input wire logic       o_bvalid,
    input wire logic       o_rvalid,
    input wire logic [1:0] o_rresp,
    input wire logic [4:0] o_resolution,
    input wire logic       o_busy,
    input wire logic       o_integ_reset,
    input wire logic       o_quantize,
    input wire logic [3:0] o_s2_gain,
    input wire logic       o_sample_clk
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // Bus answers and refusals
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    a_write_blocked: assert property (o_bvalid |-> !o_awready)
        else $error("write address taken during response");
    a_read_blocked: assert property (o_rvalid |-> !o_arready)
        else $error("read address taken during response");
    // Resolution stays within the register width
    a_res_range: assert property (o_resolution >= 5'h06 && o_resolution <= 5'h10)
        else $error("resolution out of range");
    // Overhead before the first and after the last conversion
    a_head_gap: assert property ($rose(o_busy) |-> (!o_integ_reset && !o_quantize) [*2])
        else $error("conversion began without head cycles");
    a_tail_gap: assert property ($fell(o_busy) |-> !$past(o_quantize))
        else $error("busy fell without tail cycles");
    a_s2_decode: assert property (o_s2_gain inside {4'h1, 4'h2, 4'h5, 4'ha})
        else $error("stage two gain not a legal value");
    a_quant_busy: assert property (o_quantize |-> o_busy)
        else $error("quantize outside a sequence");
    a_sample_pulse: assert property (o_sample_clk |=> !o_sample_clk)
        else $error("sampling enable wider than one cycle");

    c_quantize: cover property ($rose(o_quantize));
    c_seq_end: cover property ($fell(o_busy));
    c_bad_read: cover property (o_rvalid && o_rresp == 2'b10);
endmodule : acs_sequencer_sva

bind acs_sequencer acs_sequencer_sva i_sva (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_awready(o_awready), .o_bvalid(o_bvalid), .o_rvalid(o_rvalid), .o_rresp(o_rresp),
    .o_resolution(o_resolution), .o_busy(o_busy), .o_integ_reset(o_integ_reset),
    .o_quantize(o_quantize), .o_s2_gain(o_s2_gain), .o_sample_clk(o_sample_clk)
);
`default_nettype wire

//--- bench/acs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer: map, decode, sequences.
// Assumes the default variant; RC and slow ticks are made here, free-running.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_tb;
    logic        i_clk, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        i_rc_tick, i_slow_tick, i_mod_bit, ir_q;
    logic [7:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0]  i_wstrb, o_enable, o_s2_gain, o_s2_offset;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sample_clk;
    logic        o_offset_neg, o_integ_reset, o_quantize, o_s1_gain10, o_busy;
    logic [1:0]  o_bresp, o_rresp, wr_resp;
    logic [6:0]  o_s3_gain_twelfths, o_s3_offset;
    logic [15:0] o_result;
    logic [4:0]  o_resolution;
    int          n_mismatch, num_checks, seed, cyc, n_int, n_smp, last_t, gap;

    acs_sequencer i_dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .i_rc_tick(i_rc_tick), .i_slow_tick(i_slow_tick), .i_mod_bit(i_mod_bit),
        .o_sample_clk(o_sample_clk), .o_offset_neg(o_offset_neg),
        .o_integ_reset(o_integ_reset), .o_quantize(o_quantize), .o_enable(o_enable),
        .o_s1_gain10(o_s1_gain10), .o_s2_gain(o_s2_gain), .o_s2_offset(o_s2_offset),
        .o_s3_gain_twelfths(o_s3_gain_twelfths), .o_s3_offset(o_s3_offset),
        .o_busy(o_busy), .o_result(o_result), .o_resolution(o_resolution)
    );

    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // RC tick period 4 clocks, slow tick 16; also the hang limit
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1) i_rc_tick <= ~i_rc_tick;
        if (cyc % 8 == 7) i_slow_tick <= ~i_slow_tick;
        if (cyc == 80000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // Counts conversion starts, sampling enables and their spacing in a sequence
    always @(posedge i_clk) begin
        if (o_busy && o_integ_reset && !ir_q) begin
            chk(32'(o_offset_neg), 32'(n_int % 2));
            n_int++;
        end
        ir_q = o_integ_reset;
        if (o_busy && o_sample_clk) begin
            if (n_int > 0 && !o_quantize) n_smp++;
            gap = cyc - last_t;
            last_t = cyc;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Write: address and data offered together, bready held until the answer
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 1'b0;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= 4'hf;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!done) begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            done = o_bvalid;
        end
        wr_resp = o_bresp;
        i_bready <= 1'b0;
        @(posedge i_clk);
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        @(posedge i_clk);
    endtask : axr

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        logic [31:0] d, e;
        logic [1:0]  r;
        int          nl, os, mb, nn, res;
        int          tab[4] = '{1, 2, 5, 10};
        int          per[4] = '{16, 32, 128, 16};
        seed = 50;
        {i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
        {i_rc_tick, i_slow_tick, i_mod_bit, ir_q} = 4'h0;
        {i_awaddr, i_araddr, i_wdata, i_wstrb} = 52'h0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        axr(acs_pkg::ADDR_STATUS, d, r);
        chk(d, 32'h0000000c);
        axr(8'h14, d, r);
        chk({d[29:0], r}, 32'h00000002);
        axw(8'h14, $random(seed));
        chk(32'(wr_resp), 32'h00000002);
        $display("test reset_map done");
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            d[10:9] = k[1:0];
            d[1:0] = 2'b00;
            e = $random(seed);
            axw(acs_pkg::ADDR_CTRL, d);
            axw(acs_pkg::ADDR_OFFSET, e);
            repeat (2) @(posedge i_clk);
            chk(32'({o_s1_gain10, o_enable}), 32'(d[8:4]));
            chk(32'(o_s2_gain), 32'(tab[k]));
            chk(32'(o_s3_gain_twelfths), 32'(d[22:16]));
            chk(32'({o_s3_offset, o_s2_offset}), 32'({e[14:8], e[3:0]}));
        end
        $display("test decode done");
        for (int c = 0; c < 32; c++) begin
            axw(acs_pkg::ADDR_CFG0, 32'(c) << 2);
            axr(acs_pkg::ADDR_STATUS, d, r);
            res = (6 + 2 * (c % 8) + c / 8 > 16) ? 16 : 6 + 2 * (c % 8) + c / 8;
            chk(32'(d[5:1]), 32'(res));
            chk(32'(o_resolution), 32'(res));
        end
        $display("test resolution done");
        for (int i = 0; i < 8; i++) begin
            nl = 1 + i % 3;
            os = i / 4;
            mb = $random(seed) & 1;
            i_mod_bit <= mb[0];
            axw(acs_pkg::ADDR_CFG0, 32'((i % 4) << 7 | nl << 5 | os << 2));
            n_int = 0;
            n_smp = 0;
            axw(acs_pkg::ADDR_CTRL, (i % 2) ? 32'h000000f2 : 32'h000000f1);
            chk(32'(o_busy), 32'h1);
            axw(acs_pkg::ADDR_CTRL, 32'h000000f1);
            while (o_busy !== 1'b0) @(posedge i_clk);
            nn = 1 << nl;
            res = (((mb ? nn + 1 : nn) / 2) * ((8 << os) + 1)) >> nl;
            chk(32'(n_int), 32'(nn));
            chk(32'(n_smp), 32'(nn * ((8 << os) + 1)));
            chk(32'(gap), 32'(per[i % 4]));
            chk(32'(o_result), 32'(res));
            repeat (40) @(posedge i_clk);
            chk(32'(o_busy), 32'h0);
        end
        axw(acs_pkg::ADDR_RESULT, $random(seed));
        chk(32'(wr_resp), 32'h0);
        axr(acs_pkg::ADDR_RESULT, d, r);
        chk(d, 32'(res));
        $display("test conversions done");
        tally_and_finish();
    end
endmodule : acs_sequencer_tb
`default_nettype wire
